// ===== rtl/lcp_pkg.sv
// Notes on behaviour
// - Every sublink keeps its own CRC
// - Lanes bit 0 upward, control line last
// - Sublinks above 0 use control zero
// - 512 bit-time window, CRC at 64
// - No CRC first window, slots excluded
// - Count from first packet after sync
// - Control line high during CRC slot
// - Polynomial constant 04C11DB7
// - Seed all ones each window
// - No zero bits appended
// - Transmit inverted CRC
// - Nine bits per bit-time, shift-xor
// - Mismatch sets that lane's error bit
// - Error marks link suspect, selectable action
// - Hold error sixteen bit-times for flood
// - Logs sticky, write one clears
// - Unchecked log bits read zero
// - First generation defers while control low
// - Control low too long logs protocol
// - Data unsafe until later control
// - Peer reset: control low, lanes high
package lcp_pkg;
  localparam int          LANE_W      = 8;
  localparam logic [31:0] CRC_POLY    = 32'h04C11DB7;
  localparam logic [31:0] CRC_SEED    = 32'hFFFFFFFF;
  localparam int          WIN_BT      = 512;
  localparam int          SLOT_AT     = 64;
  localparam int          SLOT_BT     = 4;
  localparam int          HOLD_BT     = 16;
  localparam int          POS_W       = 10;
  localparam logic [9:0]  SLOT_FIRST  = POS_W'(SLOT_AT);
  localparam logic [9:0]  SLOT_LAST   = POS_W'(SLOT_AT + SLOT_BT - 1);
  localparam logic [9:0]  END_FIRST   = POS_W'(WIN_BT - 1);
  localparam logic [9:0]  END_LATER   = POS_W'(WIN_BT + SLOT_BT - 1);
  // Timing at a 4 ns system clock
  localparam int          CLK_PS        = 4000;
  localparam int          LINK_PERIOD_NS = 32;
  localparam int          LINK_DIV_DEF  = LINK_PERIOD_NS * 1000 / CLK_PS;
  localparam int          CTL_TO_SHORT_NS = 1000;
  localparam int          CTL_TO_LONG_NS  = 1000000;
  localparam int          CTL_TO_SHORT_CYC = CTL_TO_SHORT_NS * 1000 / CLK_PS;
  localparam int          CTL_TO_LONG_CYC  = CTL_TO_LONG_NS / CLK_PS * 1000;
  // Register map, byte addresses
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_LOG     = 8'h04;
  localparam logic [7:0]  REG_STATE   = 8'h08;
  localparam logic [31:0] CTRL_RST    = 32'h00000000;
  localparam int          CTRL_FIRST_GENERATION_PROTOCOL   = 0;
  localparam int          CTRL_TOLONG = 1;
  localparam int          CTRL_FLOOD  = 2;
  localparam int          CTRL_FATAL  = 3;
  localparam int          CTRL_NONFAT = 4;
  localparam int          CTRL_W      = 5;
  localparam int          LOG_CRC     = 0;
  localparam int          LOG_PROTO   = 4;
  localparam int          ST_SYNCED   = 0;
  localparam int          ST_LRST     = 1;
  localparam int          ST_SAFE     = 2;
  localparam int          ST_PEND     = 3;
  typedef enum logic [1:0] {CK_IDLE, CK_HOLD, CK_DEFER} lcp_chk_t;
endpackage

// ===== rtl/lcp_link_if.sv
`timescale 1ns/1ps
// Link wires between transmitting and receiving ends
interface lcp_link_if #(parameter int SUBLINKS = 4);
  logic                       link_clk;
  logic                       link_control_line;
  logic                       link_reset;
  logic [8*SUBLINKS-1:0]      cmd_addr_data_lanes;
  modport tx_end (output link_clk, output link_control_line, output link_reset,
                  output cmd_addr_data_lanes);
  modport rx_end (input link_clk, input link_control_line, input link_reset,
                  input cmd_addr_data_lanes);
endinterface // lcp_link_if

// ===== rtl/lcp_crc_lane.sv
`timescale 1ns/1ps
// One sublink accumulator, nine bits per step
module lcp_crc_lane
  import lcp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        step,
  input  wire logic        seed,
  input  wire logic [8:0]  data9,
  output logic      [31:0] crc
);
  // shift then reduce; polynomial; no zero tail
  function automatic logic [31:0] crc9(input logic [31:0] c, input logic [8:0] d);
    logic [31:0] r;
    logic        top;
    integer      i;
    r = c;
    for (i = 0; i < 9; i++) begin
      top = r[31];
      r   = {r[30:0], d[i]};
      if (top) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  // seed all ones at window start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc <= CRC_SEED;
    end else if (step) begin
      crc <= crc9(seed ? CRC_SEED : crc, data9);
    end
  end
endmodule // lcp_crc_lane

// ===== rtl/lcp_link_tx.sv
`timescale 1ns/1ps
// Transmitting end: makes the link clock and inserts periodic CRC
module lcp_link_tx
  import lcp_pkg::*;
#(
  parameter int SUBLINKS = 4,
  parameter int LINK_DIV = LINK_DIV_DEF
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic                  TX_LINK_RESET,
  input  wire logic [8*SUBLINKS-1:0] TX_CAD,
  input  wire logic                  TX_CTL,
  input  wire logic                  TX_VALID,
  output logic                       TX_READY,
  output logic                       TX_TAKE,
  lcp_link_if.tx_end                 LINK
);
  localparam logic [7:0] HALF = 8'(LINK_DIV / 2 - 1);

  if (!(SUBLINKS == 1 || SUBLINKS == 2 || SUBLINKS == 4)) begin : g_bad_w
    $error("SUBLINKS must be 1, 2 or 4");
  end
  if (LINK_DIV < 4 || LINK_DIV > 256 || LINK_DIV % 2 != 0) begin : g_bad_d
    $error("LINK_DIV must be even, 4 to 256");
  end

  logic [7:0]            div_cnt;
  logic                  lclk;
  logic                  fall;
  logic [POS_W-1:0]      pos;
  logic                  first_win;
  logic                  slot;
  logic [POS_W-1:0]      next_pos;
  logic                  next_first;
  logic                  take;
  logic [8*SUBLINKS-1:0] cad_now;
  logic                  ctl_now;
  logic [31:0]           crc [SUBLINKS];
  logic [31:0]           saved [SUBLINKS];
  logic [1:0]            byte_sel;

  // Link clock divider; data changes on the falling edge
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      div_cnt <= 8'h00;
      lclk    <= 1'b0;
    end else if (div_cnt == HALF) begin
      div_cnt <= 8'h00;
      lclk    <= ~lclk;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign fall = (div_cnt == HALF) && lclk;

  // first window carries no slot; slot at 64..67
  assign slot       = !first_win && pos >= SLOT_FIRST && pos <= SLOT_LAST;
  assign byte_sel   = 2'(pos - SLOT_FIRST);
  assign next_first = first_win && pos != END_FIRST;
  assign next_pos   = (pos == (first_win ? END_FIRST : END_LATER)) ? '0 : pos + 1'b1;
  assign take       = fall && TX_READY && TX_VALID && !TX_LINK_RESET;
  // Idle bit-times carry a control word of zeros
  assign cad_now    = take ? TX_CAD : '0;
  assign ctl_now    = take ? TX_CTL : 1'b1;

  // window count restarts when reset signalling ends
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      pos       <= '0;
      first_win <= 1'b1;
      TX_READY  <= 1'b0;
    end else if (fall) begin
      if (TX_LINK_RESET) begin
        pos       <= '0;
        first_win <= 1'b1;
        TX_READY  <= 1'b0;
      end else begin
        pos       <= next_pos;
        first_win <= next_first;
        TX_READY  <= next_first || next_pos < SLOT_FIRST || next_pos > SLOT_LAST;
      end
    end
  end

  // Per sublink accumulators; independent per byte lane
  for (genvar k = 0; k < SUBLINKS; k++) begin : g_lane
    logic [8:0] d9;
    // lanes first, control last; upper sublinks use zero
    assign d9 = {(k == 0) ? ctl_now : 1'b0, cad_now[k*LANE_W +: LANE_W]};
    lcp_crc_lane u_crc (
      .clk   (CLK_SYS),
      .rst   (RST),
      .step  (fall && !TX_LINK_RESET && !slot),
      .seed  (pos == '0),
      .data9 (d9),
      .crc   (crc[k])
    );
    // Finished window value kept for the next window's slot
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        saved[k] <= CRC_SEED;
      end else if (fall && !TX_LINK_RESET && pos == '0) begin
        saved[k] <= crc[k];
      end
    end
    // inverted CRC, low byte first; reset pattern
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        LINK.cmd_addr_data_lanes[k*LANE_W +: LANE_W] <= '1;
      end else if (fall) begin
        if (TX_LINK_RESET) begin
          LINK.cmd_addr_data_lanes[k*LANE_W +: LANE_W] <= '1;
        end else if (slot) begin
          LINK.cmd_addr_data_lanes[k*LANE_W +: LANE_W] <= ~saved[k][byte_sel*LANE_W +: LANE_W];
        end else begin
          LINK.cmd_addr_data_lanes[k*LANE_W +: LANE_W] <= cad_now[k*LANE_W +: LANE_W];
        end
      end
    end
  end

  // Control line, reset wire and take pulse
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      LINK.link_control_line <= 1'b0;
      LINK.link_reset        <= 1'b1;
      TX_TAKE                <= 1'b0;
    end else begin
      TX_TAKE <= take;
      if (fall) begin
        LINK.link_reset <= TX_LINK_RESET;
        // control held high through the slot
        LINK.link_control_line <= !TX_LINK_RESET && (slot || ctl_now);
      end
    end
  end
  assign LINK.link_clk = lclk;
endmodule // lcp_link_tx

// ===== rtl/lcp_link_rx.sv
// Local design decisions: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
// Receiving end: periodic CRC check, error logs, Wishbone registers
module lcp_link_rx
  import lcp_pkg::*;
#(
  parameter int SUBLINKS        = 4,
  parameter int CTL_TO_LONG     = CTL_TO_LONG_CYC
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic                  WB_CYC_I,
  input  wire logic                  WB_STB_I,
  input  wire logic                  WB_WE_I,
  input  wire logic [7:0]            WB_ADR_I,
  input  wire logic [3:0]            WB_SEL_I,
  input  wire logic [31:0]           WB_DAT_I,
  output logic      [31:0]           WB_DAT_O,
  output logic                       WB_ACK_O,
  output logic      [8*SUBLINKS-1:0] RX_CAD,
  output logic                       RX_CTL,
  output logic                       RX_VALID,
  output logic                       RX_DATA_SAFE,
  output logic                       LINK_SUSPECT,
  output logic                       SYNC_FLOOD_REQ,
  output logic                       FATAL_ERR,
  output logic                       NONFATAL_ERR,
  lcp_link_if.rx_end                 LINK
);
  if (!(SUBLINKS == 1 || SUBLINKS == 2 || SUBLINKS == 4)) begin : g_bad_w
    $error("SUBLINKS must be 1, 2 or 4");
  end
  if (CTL_TO_LONG <= CTL_TO_SHORT_CYC) begin : g_bad_t
    $error("CTL_TO_LONG must exceed the short timeout");
  end

  logic                  clk_s1, clk_s2, clk_s3;
  logic                  ctl_s1, ctl_s2;
  logic                  lrst_s1, lrst_s2;
  logic [8*SUBLINKS-1:0] cad_s1, cad_s2;
  logic                  bt;
  logic                  started;
  logic                  first_win;
  logic [POS_W-1:0]      pos;
  logic [POS_W-1:0]      pos_cur;
  logic                  fw_cur;
  logic                  active;
  logic                  slot;
  logic [1:0]            byte_sel;
  logic                  flood_bt;
  logic [31:0]           crc [SUBLINKS];
  logic [31:0]           saved [SUBLINKS];
  logic [SUBLINKS-1:0]   mism;
  logic [SUBLINKS-1:0]   pend;
  lcp_chk_t              chk;
  logic [4:0]            hold_cnt;
  logic [SUBLINKS-1:0]   crc_set;
  logic [3:0]            crc_log;
  logic                  proto_log;
  logic                  proto_set;
  logic [31:0]           to_cnt;
  logic [31:0]           to_lim;
  logic [CTRL_W-1:0]     ctrl;
  logic                  wb_req;
  logic                  wr_log;
  logic [31:0]           rd_data;

  // Pin sampling, two flops before any use
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      clk_s1  <= 1'b0;
      clk_s2  <= 1'b0;
      clk_s3  <= 1'b0;
      ctl_s1  <= 1'b0;
      ctl_s2  <= 1'b0;
      lrst_s1 <= 1'b1;
      lrst_s2 <= 1'b1;
      cad_s1  <= '0;
      cad_s2  <= '0;
    end else begin
      clk_s1  <= LINK.link_clk;
      clk_s2  <= clk_s1;
      clk_s3  <= clk_s2;
      ctl_s1  <= LINK.link_control_line;
      ctl_s2  <= ctl_s1;
      lrst_s1 <= LINK.link_reset;
      lrst_s2 <= lrst_s1;
      cad_s1  <= LINK.cmd_addr_data_lanes;
      cad_s2  <= cad_s1;
    end
  end
  assign bt = clk_s2 && !clk_s3;

  // first control bit-time after reset is position zero
  assign active   = !lrst_s2 && (started || ctl_s2);
  assign pos_cur  = started ? pos : '0;
  assign fw_cur   = started ? first_win : 1'b1;
  // slot at 64..67; none in the first window
  assign slot     = !fw_cur && pos_cur >= SLOT_FIRST && pos_cur <= SLOT_LAST;
  assign byte_sel = 2'(pos_cur - SLOT_FIRST);
  assign flood_bt = ctl_s2 && (&cad_s2);

  // Window position tracking
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      started   <= 1'b0;
      first_win <= 1'b1;
      pos       <= '0;
    end else if (bt) begin
      if (!active) begin
        started   <= 1'b0;
        first_win <= 1'b1;
        pos       <= '0;
      end else begin
        started   <= 1'b1;
        first_win <= fw_cur && pos_cur != END_FIRST;
        pos       <= (pos_cur == (fw_cur ? END_FIRST : END_LATER)) ? '0 : pos_cur + 1'b1;
      end
    end
  end

  for (genvar k = 0; k < SUBLINKS; k++) begin : g_lane
    logic [8:0] d9;
    // lanes then control; upper sublinks take zero
    assign d9 = {(k == 0) ? ctl_s2 : 1'b0, cad_s2[k*LANE_W +: LANE_W]};
    lcp_crc_lane u_crc (
      .clk   (CLK_SYS),
      .rst   (RST),
      .step  (bt && active && !slot),
      .seed  (pos_cur == '0),
      .data9 (d9),
      .crc   (crc[k])
    );
    // compare re-inverted bytes with the stored window
    always_ff @(posedge CLK_SYS or posedge RST) begin
      if (RST) begin
        saved[k] <= CRC_SEED;
        mism[k]  <= 1'b0;
      end else if (bt && active) begin
        if (pos_cur == '0) begin
          saved[k] <= crc[k];
        end
        if (slot) begin
          mism[k] <= (pos_cur == SLOT_FIRST ? 1'b0 : mism[k])
                   | (~cad_s2[k*LANE_W +: LANE_W] != saved[k][byte_sel*LANE_W +: LANE_W]);
        end
      end
    end
  end

  // hold sixteen bit-times so a flood wins; defer
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      chk      <= CK_IDLE;
      hold_cnt <= 5'h00;
      pend     <= '0;
      crc_set  <= '0;
    end else begin
      crc_set <= '0;
      case (chk)
        CK_IDLE: begin
          // Mismatch flags from before a link reset are stale in the first window
          if (bt && active && !slot && !fw_cur && pos_cur == SLOT_LAST + 1'b1 && |mism) begin
            pend     <= mism;
            hold_cnt <= 5'(HOLD_BT - 1);
            chk      <= CK_HOLD;
          end
        end
        CK_HOLD: begin
          if (lrst_s2 || (bt && flood_bt)) begin
            chk <= CK_IDLE;
          end else if (bt) begin
            if (hold_cnt != 5'h00) begin
              hold_cnt <= hold_cnt - 5'h01;
            end else if (ctrl[CTRL_FIRST_GENERATION_PROTOCOL] && !ctl_s2) begin
              chk <= CK_DEFER;
            end else begin
              crc_set <= pend;
              chk     <= CK_IDLE;
            end
          end
        end
        CK_DEFER: begin
          // link reset first drops the error
          if (lrst_s2) begin
            chk <= CK_IDLE;
          end else if (bt && ctl_s2) begin
            crc_set <= pend;
            chk     <= CK_IDLE;
          end
        end
        default: chk <= CK_IDLE;
      endcase
    end
  end

  // control low beyond the selected timeout
  assign to_lim = ctrl[CTRL_TOLONG] ? 32'(CTL_TO_LONG) : 32'(CTL_TO_SHORT_CYC);
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      to_cnt    <= 32'h00000000;
      proto_set <= 1'b0;
    end else begin
      proto_set <= 1'b0;
      if (ctl_s2 || lrst_s2 || !started) begin
        to_cnt <= 32'h00000000;
      end else if (to_cnt != to_lim) begin
        to_cnt    <= to_cnt + 32'h00000001;
        proto_set <= (to_cnt + 32'h00000001 == to_lim);
      end
    end
  end

  // Wishbone slave, one wait state, unmapped reads zero; writes land on the ack edge
  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wr_log = WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0]
                  && WB_ADR_I == REG_LOG;
  always_comb begin
    rd_data = 32'h00000000;
    case (WB_ADR_I)
      REG_CTRL:  rd_data[CTRL_W-1:0] = ctrl;
      // unchecked and absent lanes read zero
      REG_LOG:   rd_data[LOG_PROTO:LOG_CRC] = {proto_log, crc_log};
      REG_STATE: rd_data[ST_PEND:ST_SYNCED] = {chk != CK_IDLE, RX_DATA_SAFE,
                                               lrst_s2, started};
      default:   rd_data = 32'h00000000;
    endcase
  end
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
      ctrl     <= CTRL_RST[CTRL_W-1:0];
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= wb_req ? rd_data : 32'h00000000;
      if (WB_CYC_I && WB_STB_I && WB_ACK_O && WB_WE_I && WB_SEL_I[0]
          && WB_ADR_I == REG_CTRL) begin
        ctrl <= WB_DAT_I[CTRL_W-1:0];
      end
    end
  end

  // lane error bits and protocol bit; sticky, write one clears, set wins
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      crc_log   <= 4'h0;
      proto_log <= 1'b0;
    end else begin
      crc_log   <= (crc_log & ~(wr_log ? WB_DAT_I[LOG_CRC +: 4] : 4'h0))
                 | 4'(crc_set);
      proto_log <= (proto_log && !(wr_log && WB_DAT_I[LOG_PROTO])) || proto_set;
    end
  end

  // suspect until link reset; error actions by enable
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      LINK_SUSPECT   <= 1'b0;
      SYNC_FLOOD_REQ <= 1'b0;
      FATAL_ERR      <= 1'b0;
      NONFATAL_ERR   <= 1'b0;
    end else begin
      LINK_SUSPECT   <= !lrst_s2 && (LINK_SUSPECT || |crc_set);
      SYNC_FLOOD_REQ <= ctrl[CTRL_FLOOD] && (|crc_log || proto_log);
      FATAL_ERR      <= ctrl[CTRL_FATAL] && (|crc_log || proto_log);
      NONFATAL_ERR   <= ctrl[CTRL_NONFAT] && (|crc_log || proto_log);
    end
  end

  // User data out; data unsafe until a later control word
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      RX_CAD       <= '0;
      RX_CTL       <= 1'b0;
      RX_VALID     <= 1'b0;
      RX_DATA_SAFE <= 1'b0;
    end else begin
      RX_VALID <= bt && active && !slot;
      if (lrst_s2) begin
        RX_DATA_SAFE <= 1'b0;
      end else if (bt && active && !slot) begin
        RX_CAD       <= cad_s2;
        RX_CTL       <= ctl_s2;
        RX_DATA_SAFE <= ctl_s2;
      end
    end
  end
endmodule // lcp_link_rx

// ===== verif/lcp_link_sva.sv
`timescale 1ns/1ps
// Rebuilds each sublink CRC from the wire and checks every slot
module lcp_link_sva
  import lcp_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        RST,
  input wire logic        link_clk,
  input wire logic        link_control_line,
  input wire logic        link_reset,
  input wire logic [31:0] cmd_addr_data_lanes
);
  logic        clk_q, started, first, rise, live, slot, wend;
  logic [9:0]  pos, cur;
  logic [31:0] acc [4];
  logic [31:0] prev [4];
  logic [31:0] nxt [4];
  logic [7:0]  exp_b [4];

  // One bit-time of nine bits, lane bit 0 first
  function automatic logic [31:0] step9(input logic [31:0] c, input logic [8:0] d);
    logic t;
    for (int i = 0; i < 9; i++) begin
      t = c[31];
      c = {c[30:0], d[i]};
      c = t ? c ^ CRC_POLY : c;
    end
    return c;
  endfunction

  // The link clock is only sampled, so a rise marks one bit-time
  assign rise = link_clk & ~clk_q;
  assign live = rise & ~link_reset & (started | link_control_line);
  assign cur  = started ? pos : 10'h000;
  assign slot = ~first & (cur >= SLOT_FIRST) & (cur <= SLOT_LAST);
  assign wend = live & (cur == (first ? END_FIRST : END_LATER));
  // Control feeds sublink 0 only
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      nxt[k]   = step9(acc[k], {(k == 0) & link_control_line, cmd_addr_data_lanes[8*k +: 8]});
      exp_b[k] = ~prev[k][8*cur[1:0] +: 8];
    end
  end
  // Window position, restarted by every link reset
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      clk_q   <= 1'b0;
      started <= 1'b0;
      first   <= 1'b1;
      pos     <= 10'h000;
    end else begin
      clk_q <= link_clk;
      if (link_reset) begin
        started <= 1'b0;
        first   <= 1'b1;
        pos     <= 10'h000;
      end else if (live) begin
        started <= 1'b1;
        pos     <= wend ? 10'h000 : cur + 10'h001;
        first   <= first & ~wend;
      end
    end
  end
  // Reference sums; slot bit-times stay out so later windows span 516
  always_ff @(posedge CLK_SYS or posedge RST) begin
    for (int k = 0; k < 4; k++) begin
      if (RST || link_reset) begin
        acc[k]  <= CRC_SEED;
        prev[k] <= CRC_SEED;
      end else if (live & ~slot) begin
        acc[k]  <= wend ? CRC_SEED : nxt[k];
        prev[k] <= wend ? nxt[k] : prev[k];
      end
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  a_crc_sub0 : assert property (
    live && slot |-> cmd_addr_data_lanes[7:0] == exp_b[0]) else $error("sublink 0 slot wrong");
  a_crc_sub1 : assert property (
    live && slot |-> cmd_addr_data_lanes[15:8] == exp_b[1]) else $error("sublink 1 slot wrong");
  a_crc_sub2 : assert property (
    live && slot |-> cmd_addr_data_lanes[23:16] == exp_b[2]) else $error("sublink 2 slot wrong");
  a_crc_sub3 : assert property (
    live && slot |-> cmd_addr_data_lanes[31:24] == exp_b[3]) else $error("sublink 3 slot wrong");
  a_slot_ctl_high : assert property (
    live && slot |-> link_control_line) else $error("control low in slot");
  a_reset_lanes : assert property (
    link_reset |-> !link_control_line && (&cmd_addr_data_lanes)) else $error("bad reset level");
  a_first_ctl : assert property (
    rise && !link_reset && !started |-> link_control_line) else $error("first bit-time not control");
  a_lanes_steady : assert property (
    link_clk && $past(link_clk) |-> $stable(cmd_addr_data_lanes) && $stable(link_control_line))
    else $error("lanes moved while clock high");
endmodule // lcp_link_sva

// ===== verif/tb.sv
`timescale 1ns/1ps
// Two ends face each other; a second receiver sees a tampered copy of the lanes
module tb;
  import lcp_pkg::*;
  logic        CLK_SYS, RST, TX_LINK_RESET, TX_CTL, TX_VALID, TX_READY, TX_TAKE;
  logic        WB_CYC_I, WB_STB_I, WB_WE_I, ack_a, safe_a, rsel, rx_ctl, rx_vld;
  logic [7:0]  WB_ADR_I;
  logic [31:0] WB_DAT_I, TX_CAD, dat_a, dat_b, rx_cad, flip;
  logic [3:0]  err_b, WB_SEL_I;
  logic [32:0] sent [$];
  int          fail_count = 0;
  int          comparisons = 0;

  lcp_link_if lk ();
  lcp_link_if l2 ();
  // Only the lanes of the copy can be flipped
  assign l2.link_clk = lk.link_clk;
  assign l2.link_control_line = lk.link_control_line;
  assign l2.link_reset = lk.link_reset;
  assign l2.cmd_addr_data_lanes = lk.cmd_addr_data_lanes ^ flip;

  lcp_link_tx i_lcp_link_tx (.CLK_SYS(CLK_SYS), .RST(RST),
    .TX_LINK_RESET(TX_LINK_RESET), .TX_CAD(TX_CAD), .TX_CTL(TX_CTL), .TX_VALID(TX_VALID),
    .TX_READY(TX_READY), .TX_TAKE(TX_TAKE), .LINK(lk));
  lcp_link_rx #(.CTL_TO_LONG(1000)) i_lcp_link_rx (.CLK_SYS(CLK_SYS),
    .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(dat_a),
    .WB_ACK_O(ack_a), .RX_CAD(rx_cad), .RX_CTL(rx_ctl), .RX_VALID(rx_vld),
    .RX_DATA_SAFE(safe_a), .LINK_SUSPECT(), .SYNC_FLOOD_REQ(), .FATAL_ERR(),
    .NONFATAL_ERR(), .LINK(lk));
  lcp_link_rx #(.CTL_TO_LONG(1000)) i_lcp_link_rx_b (.CLK_SYS(CLK_SYS),
    .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(dat_b),
    .WB_ACK_O(), .RX_CAD(), .RX_CTL(), .RX_VALID(), .RX_DATA_SAFE(),
    .LINK_SUSPECT(err_b[3]), .SYNC_FLOOD_REQ(err_b[2]), .FATAL_ERR(err_b[1]),
    .NONFATAL_ERR(err_b[0]), .LINK(l2));
  lcp_link_sva i_lcp_link_sva (.CLK_SYS(CLK_SYS), .RST(RST), .link_clk(lk.link_clk),
    .link_control_line(lk.link_control_line), .link_reset(lk.link_reset),
    .cmd_addr_data_lanes(lk.cmd_addr_data_lanes));

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle; both receivers share the bus and answer together
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge CLK_SYS);
    {WB_CYC_I, WB_STB_I, WB_WE_I} <= {2'b11, we};
    WB_ADR_I <= a;
    WB_DAT_I <= d;
    do @(posedge CLK_SYS); while (ack_a !== 1'b1);
    q = rsel ? dat_b : dat_a;
    {WB_CYC_I, WB_STB_I} <= 2'b00;
  endtask
  task automatic rd(input logic s, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    rsel = s;
    wb(1'b0, a, 32'h0, q);
    chk({1'b0, q}, {1'b0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  // Counts link bit-times by the transmitter's own takes
  task automatic takes(input int n);
    repeat (n) @(posedge CLK_SYS iff TX_TAKE === 1'b1);
  endtask
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end
  // New word after each take; never the idle or flood pattern
  always @(posedge CLK_SYS) begin
    if (TX_TAKE === 1'b1) begin
      sent.push_back({TX_CTL, TX_CAD});
      TX_CAD <= TX_CAD + 32'h1;
    end
  end
  // Idle bit-times are skipped, slot bit-times must never surface
  always @(posedge CLK_SYS) begin
    if (rx_vld === 1'b1 && {rx_ctl, rx_cad} !== 33'h100000000) begin
      chk({rx_ctl, rx_cad}, (sent.size() > 0) ? sent.pop_front() : 33'h0);
    end
  end
  initial begin
    repeat (30000) @(posedge CLK_SYS);
    fail_count++;
    $display("Error at %0t: timeout", $time);
    end_of_test();
  end

  initial begin
    {RST, TX_LINK_RESET, TX_CTL, TX_VALID} = 4'b1110;
    {WB_CYC_I, WB_STB_I, WB_WE_I, rsel} = 4'h0;
    WB_SEL_I = 4'hF;
    {WB_ADR_I, WB_DAT_I, flip} = {8'h00, 64'h0};
    TX_CAD = 32'hA5000001;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    // Reset values, write mask, select bit 0 and an unmapped address
    rd(1'b0, REG_CTRL, CTRL_RST);
    wr(REG_CTRL, 32'hFFFFFFFF);
    rd(1'b0, REG_CTRL, 32'h0000001F);
    WB_SEL_I <= 4'hE;
    wr(REG_CTRL, 32'h00000000);
    WB_SEL_I <= 4'hF;
    rd(1'b0, REG_CTRL, 32'h0000001F);
    wr(8'hFC, 32'hFFFFFFFF);
    rd(1'b0, 8'hFC, 32'h00000000);
    wr(REG_LOG, 32'hFFFFFFFF);
    rd(1'b1, REG_LOG, 32'h00000000);
    wr(REG_CTRL, 32'h0000001C);
    // One bad bit-time on sublink 2 in the first window
    TX_LINK_RESET <= 1'b0;
    TX_VALID <= 1'b1;
    takes(100);
    flip <= 32'h00040000;
    repeat (8) @(posedge CLK_SYS);
    flip <= 32'h0;
    takes(520);
    rd(1'b1, REG_LOG, 32'h00000004);
    rd(1'b0, REG_LOG, 32'h00000000);
    chk({29'h0, err_b}, 33'hF);
    // Warm reset keeps the log; only a written one clears it
    TX_VALID <= 1'b0;
    repeat (40) @(posedge CLK_SYS);
    TX_LINK_RESET <= 1'b1;
    repeat (80) @(posedge CLK_SYS);
    rd(1'b1, REG_LOG, 32'h00000004);
    TX_LINK_RESET <= 1'b0;
    TX_VALID <= 1'b1;
    wr(REG_LOG, 32'h00000004);
    rd(1'b1, REG_LOG, 32'h00000000);
    // Control held low past the short timeout
    takes(10);
    TX_CTL <= 1'b0;
    takes(40);
    chk({32'h0, safe_a}, 33'h0);
    TX_CTL <= 1'b1;
    takes(4);
    chk({32'h0, safe_a}, 33'h1);
    rd(1'b0, REG_LOG, 32'h00000010);
    // Past the next slot with control-low data inside: no false errors
    takes(600);
    rd(1'b0, REG_LOG, 32'h00000010);
    rd(1'b1, REG_LOG, 32'h00000010);
    end_of_test();
  end
endmodule // tb
